// File: inc/rrfd_consts.vh
/*
 Constants for the rotate and round flag datapath slice.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef RRFD_CONSTS_VH
`define RRFD_CONSTS_VH
// Operation codes
`define RRFD_OP_NONE 3'h0
`define RRFD_OP_LEFT 3'h1
`define RRFD_OP_LEFT_CY 3'h2
`define RRFD_OP_RIGHT 3'h3
`define RRFD_OP_RIGHT_CY 3'h4
`define RRFD_OP_RND 3'h5
// Destination register numbering
`define RRFD_DST_W 5
`define RRFD_EXT_LAST 5'h07
// Extended-precision word layout
`define RRFD_EXP_MSB 39
`define RRFD_EXP_LSB 32
`define RRFD_MANT_MSB 31
`define RRFD_ROUND_BIT 7
`define RRFD_EXP_MAX 8'h7f
`define RRFD_EXP_ZERO 8'h80
// Flag reset value
`define RRFD_FLAG_RST 1'h0
`endif

// File: rtl/rrfd_rounder.v
/*
 Single-precision rounding of an extended-precision float.
 Assumes 8-bit exponent over 32-bit two's complement mantissa.
*/
`include "rrfd_consts.vh"
module rrfd_round (
   // Operand and mode
   input wire [39:0] src,
   input wire sat_mode,
   // Result and events
   output reg [39:0] res,
   output reg ovf,
   output reg unf,
   output reg zero_src
);
   reg [7:0] exp_v;
   reg [32:0] sum;
   reg [31:0] man;
   reg [7:0] exp_n;
   // Round half up on the two's complement mantissa
   always @* begin
      exp_v = src[`RRFD_EXP_MSB:`RRFD_EXP_LSB];
      zero_src = (exp_v == `RRFD_EXP_ZERO);
      sum = {src[31], src[31:0]} + 33'h000000080;
      sum = {sum[32:8], 8'h00};
      man = sum[31:0];
      exp_n = exp_v;
      ovf = 1'b0;
      unf = 1'b0;
      // Mantissa left the range: renormalise by one
      if (sum[32] != sum[31]) begin
         man = sum[32:1];
         man = {man[31:8], 8'h00};
         if (exp_v == `RRFD_EXP_MAX) begin
            ovf = 1'b1;
         end else begin
            exp_n = exp_v + 8'h01;
         end
      end
      res = {exp_n, man};
      if (zero_src) begin
         res = src;
         unf = 1'b0;
      end else if (ovf) begin
         // Saturate when mode bit set, else renormalised mantissa at the largest exponent
         if (sat_mode) begin
            res = man[31] ? {`RRFD_EXP_MAX, 32'h80000000} :
               {`RRFD_EXP_MAX, 32'h7fffff00};
         end else begin
            res = {`RRFD_EXP_MAX, man};
         end
      end
   end
endmodule

// File: rtl/rrfd_datapath.v
/*
 Rotate and round execution slice: computes the destination word
 and updates the condition flags in one cycle per instruction.
 Assumes decode presents op, dst number and operands for one cycle
 with op_valid, and the register file writes back wr_data on wr_en.
*/
//
// Operation
// - rotate left copies msb to lsb, carry
// - rotate left through carry, carry into lsb
// - rotate right copies lsb to msb, carry
// - rotate right through carry, 33-bit ring
// - flags change only for registers R7-R0
// - zero, negative set; overflow, underflow cleared
// - plain rotates keep carry for other registers
// - through-carry feeds carry, keeps it elsewhere
// - rotates ignore overflow mode bit
// - rounding honours overflow mode bit
// - rounding zero leaves zero flag unchanged
// - round to nearest, halfway goes positive
`include "rrfd_consts.vh"
module rrfd_datapath (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Instruction from decode
   input wire op_valid,
   input wire [2:0] op,
   input wire [4:0] dst,
   input wire [39:0] dst_data,
   input wire [39:0] src_data,
   input wire overflow_mode_bit,
   // Write back
   output reg wr_en,
   output reg [4:0] wr_dst,
   output reg [39:0] wr_data,
   // Condition flags
   output reg carry_flag,
   output reg overflow_flag,
   output reg zero_flag,
   output reg negative_flag,
   output reg underflow_flag,
   output reg latched_overflow_flag,
   output reg latched_underflow_flag
);
   ////////////////////////////////////////////////////////////////////
   // Rounder results
   wire [39:0] rnd_res;
   wire rnd_ovf;
   wire rnd_unf;
   wire rnd_zero;
   // Decode of the instruction
   reg op_rotl;
   reg op_rotl_c;
   reg op_rotr;
   reg op_rotr_c;
   reg op_round;
   wire is_rot;
   wire ext_dst;
   // Destination word parts
   wire [31:0] field;
   wire [7:0] exp_keep;
   // Per-bit rotate taps
   wire left_fill;
   wire right_fill;
   wire [31:0] left_v;
   wire [31:0] right_v;
   // Rotate result and bit rotated out
   reg [31:0] rot;
   reg out_bit;
   // Next values of the write port and the flags
   reg wr_en_d;
   reg [4:0] wr_dst_d;
   reg [39:0] wr_data_d;
   reg carry_d;
   reg overflow_d;
   reg zero_d;
   reg negative_d;
   reg underflow_d;
   reg lat_ovf_d;
   reg lat_unf_d;
   genvar gi;

   // Rounder
   rrfd_round u_round (
      .src(src_data),
      .sat_mode(overflow_mode_bit),
      .res(rnd_res),
      .ovf(rnd_ovf),
      .unf(rnd_unf),
      .zero_src(rnd_zero)
   );

   //////////////////////////////////////////////////////////////////////
   // Op code decode, gated by the valid strobe
   always @* begin
      op_rotl = 1'b0;
      op_rotl_c = 1'b0;
      op_rotr = 1'b0;
      op_rotr_c = 1'b0;
      op_round = 1'b0;
      case (op)
         `RRFD_OP_LEFT: begin
            op_rotl = op_valid;
         end
         `RRFD_OP_LEFT_CY: begin
            op_rotl_c = op_valid;
         end
         `RRFD_OP_RIGHT: begin
            op_rotr = op_valid;
         end
         `RRFD_OP_RIGHT_CY: begin
            op_rotr_c = op_valid;
         end
         `RRFD_OP_RND: begin
            op_round = op_valid;
         end
         // Codes 0, 6 and 7 start nothing
         default: begin
            op_round = 1'b0;
         end
      endcase
   end

   // Any of the four rotates
   assign is_rot = op_rotl | op_rotl_c | op_rotr | op_rotr_c;

   // Extended-precision destination check
   assign ext_dst = (dst <= `RRFD_EXT_LAST);

   // Integer field and exponent of the destination
   assign field = dst_data[31:0];
   assign exp_keep = dst_data[`RRFD_EXP_MSB:`RRFD_EXP_LSB];

   // Bits entering at the two ends of the field
   assign left_fill = op_rotl ? field[31] : carry_flag;
   assign right_fill = op_rotr ? field[0] : carry_flag;

   // Neighbour taps, one per adjacent bit pair of the field, 31 in all
   generate
      for (gi = 0; gi < 31; gi = gi + 1) begin : g_tap
         assign left_v[gi + 1] = field[gi];
         assign right_v[gi] = field[gi + 1];
      end
   endgenerate
   assign left_v[0] = left_fill;
   assign right_v[31] = right_fill;

   // Pick the rotated field, no mode bit input
   always @* begin
      rot = field;
      out_bit = 1'b0;
      if (op_rotl | op_rotl_c) begin
         rot = left_v;
         out_bit = field[31];
      end else if (op_rotr | op_rotr_c) begin
         rot = right_v;
         out_bit = field[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next write port and flags; other ops change nothing
   always @* begin
      wr_en_d = 1'b0;
      wr_dst_d = wr_dst;
      wr_data_d = wr_data;
      carry_d = carry_flag;
      overflow_d = overflow_flag;
      zero_d = zero_flag;
      negative_d = negative_flag;
      underflow_d = underflow_flag;
      lat_ovf_d = latched_overflow_flag;
      lat_unf_d = latched_underflow_flag;
      if (is_rot) begin
         wr_en_d = 1'b1;
         wr_dst_d = dst;
         wr_data_d = {exp_keep, rot};
         // Flags, carry included, only for R7-R0
         if (ext_dst) begin
            carry_d = out_bit;
            zero_d = (rot == 32'h00000000);
            negative_d = rot[31];
            overflow_d = 1'b0;
            underflow_d = 1'b0;
         end
      end else if (op_round) begin
         wr_en_d = 1'b1;
         wr_dst_d = dst;
         wr_data_d = rnd_res;
         if (ext_dst) begin
            // Zero flag left alone, even for a zero operand
            negative_d = rnd_res[31];
            overflow_d = rnd_ovf;
            underflow_d = rnd_unf | rnd_zero;
            // Latched flags only ever set here
            lat_ovf_d = latched_overflow_flag | rnd_ovf;
            lat_unf_d = latched_underflow_flag | rnd_unf;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Write back and flag registers, single cycle
   always @(posedge clk) begin
      if (sys_rst) begin
         wr_en <= 1'b0;
         wr_dst <= 5'h00;
         wr_data <= 40'h0000000000;
         carry_flag <= `RRFD_FLAG_RST;
         overflow_flag <= `RRFD_FLAG_RST;
         zero_flag <= `RRFD_FLAG_RST;
         negative_flag <= `RRFD_FLAG_RST;
         underflow_flag <= `RRFD_FLAG_RST;
         latched_overflow_flag <= `RRFD_FLAG_RST;
         latched_underflow_flag <= `RRFD_FLAG_RST;
      end else begin
         wr_en <= wr_en_d;
         wr_dst <= wr_dst_d;
         wr_data <= wr_data_d;
         carry_flag <= carry_d;
         overflow_flag <= overflow_d;
         zero_flag <= zero_d;
         negative_flag <= negative_d;
         underflow_flag <= underflow_d;
         latched_overflow_flag <= lat_ovf_d;
         latched_underflow_flag <= lat_unf_d;
      end
   end
endmodule

// File: tb/rrfd_props.sv
/* Port checker for the rotate and round slice.
 Assumes one clock, synchronous active high reset, bound below. */
module rrfd_props (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Instruction from decode
   input wire op_valid,
   input wire [2:0] op,
   input wire [4:0] dst,
   input wire [39:0] dst_data,
   input wire [39:0] src_data,
   // Write back
   input wire wr_en,
   input wire [4:0] wr_dst,
   input wire [39:0] wr_data,
   // Condition flags
   input wire carry_flag,
   input wire overflow_flag,
   input wire zero_flag,
   input wire negative_flag,
   input wire underflow_flag,
   input wire latched_overflow_flag,
   input wire latched_underflow_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Decode and expected rotate field
   wire ext = dst <= 5'h07;
   wire go = op_valid && op != 3'h0 && op <= 3'h5;
   wire rot = go && op != 3'h5;
   wire lft = op <= 3'h2;
   wire cout = lft ? dst_data[31] : dst_data[0];
   wire cin = op[0] ? cout : carry_flag;
   wire [31:0] rx = lft ? {dst_data[30:0], cin} : {cin, dst_data[31:1]};
   wire [6:0] flg = {carry_flag, overflow_flag, zero_flag, negative_flag,
      underflow_flag, latched_overflow_flag, latched_underflow_flag};
   wire [7:0] dexp = dst_data[39:32];
   // Rotate results
   chk_left_data: assert property (op_valid && op == 3'h1 |=>
      wr_data[31:0] == $past(rx)) else $error("rotate left result");
   chk_left_carry_data: assert property (op_valid && op == 3'h2 |=>
      wr_data[31:0] == $past(rx)) else $error("left through carry result");
   chk_right_data: assert property (op_valid && op == 3'h3 |=>
      wr_data[31:0] == $past(rx)) else $error("rotate right result");
   chk_right_carry_data: assert property (op_valid && op == 3'h4 |=>
      wr_data[31:0] == $past(rx)) else $error("right through carry result");
   chk_exp_kept: assert property (rot |=>
      wr_data[39:32] == $past(dexp)) else $error("exponent not kept");
   // Round flags
   chk_round_zero: assert property (go && op == 3'h5 |=>
      $stable(zero_flag)) else $error("round changed zero flag");
   chk_zero_operand: assert property (go && op == 3'h5 && ext &&
      src_data[39:32] == 8'h80 |=> underflow_flag)
      else $error("zero operand without underflow");
   // Flags and write pulse
   chk_flags_held: assert property (go && !ext |=> $stable(flg))
      else $error("held");
   chk_rot_flags: assert property (rot && ext |=>
      zero_flag == !wr_data[31:0] && negative_flag == wr_data[31] &&
      !overflow_flag && !underflow_flag && $stable(flg[1:0]))
      else $error("flags");
   chk_rot_carry: assert property (rot && ext |=>
      carry_flag == $past(cout)) else $error("carry");
   chk_write_pulse: assert property (1'b1 |=>
      wr_en == $past(go) && (!wr_en || wr_dst == $past(dst)))
      else $error("write");
   cover property (rot && !ext);
   cover property (go && op == 3'h5 && ext);
   cover property (rot && ext && carry_flag);
   cover property (go && op == 3'h5 && src_data[39:32] == 8'h80);
endmodule
bind rrfd_datapath rrfd_props u_props (
   .clk(clk),
   .sys_rst(sys_rst),
   .op_valid(op_valid),
   .op(op),
   .dst(dst),
   .dst_data(dst_data),
   .src_data(src_data),
   .wr_en(wr_en),
   .wr_dst(wr_dst),
   .wr_data(wr_data),
   .carry_flag(carry_flag),
   .overflow_flag(overflow_flag),
   .zero_flag(zero_flag),
   .negative_flag(negative_flag),
   .underflow_flag(underflow_flag),
   .latched_overflow_flag(latched_overflow_flag),
   .latched_underflow_flag(latched_underflow_flag)
);

// File: tb/rrfd_regfile.sv
/* Register file model on the far side of the slice.
 Assumes the bench preloads entries through regs. */
module rrfd_regfile (
   // Clock and write port
   input wire clk,
   input wire wr_en,
   input wire [4:0] wr_sel,
   input wire [39:0] wr_data,
   // Read port
   input wire [4:0] rd_sel,
   output wire [39:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [39:0] regs [0:31];
   // Read by number, write back on the pulse
   assign rd_data = regs[rd_sel];
   always @(posedge clk) begin
      if (wr_en) begin
         regs[wr_sel] <= wr_data;
      end
   end
endmodule

// File: tb/rotate_round_flag_datapath_tb.sv
/* Self-checking bench for the rotate and round slice.
 Assumes the register file model and the bound checker. */
module rotate_round_flag_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   reg clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, overflow_mode_bit = 1'b0;
   reg [2:0] op = 3'h0;
   reg [4:0] dst = 5'h00;
   reg [39:0] src_data = 40'h0;
   wire [39:0] dst_data, wr_data;
   wire [4:0] wr_dst;
   wire wr_en, carry_flag, overflow_flag, zero_flag, negative_flag;
   wire underflow_flag, latched_overflow_flag, latched_underflow_flag;
   integer bad_count = 0, checked = 0;
   // Clock, slice and register file
   always #2 clk = ~clk;
   rrfd_datapath DUT (
      .clk(clk),
      .sys_rst(sys_rst),
      .op_valid(op_valid),
      .op(op),
      .dst(dst),
      .dst_data(dst_data),
      .src_data(src_data),
      .overflow_mode_bit(overflow_mode_bit),
      .wr_en(wr_en),
      .wr_dst(wr_dst),
      .wr_data(wr_data),
      .carry_flag(carry_flag),
      .overflow_flag(overflow_flag),
      .zero_flag(zero_flag),
      .negative_flag(negative_flag),
      .underflow_flag(underflow_flag),
      .latched_overflow_flag(latched_overflow_flag),
      .latched_underflow_flag(latched_underflow_flag)
   );
   rrfd_regfile P (.clk(clk), .wr_en(wr_en), .rd_sel(dst), .wr_sel(wr_dst),
      .wr_data(wr_data), .rd_data(dst_data));
   // Verdict and end of run
   task results;
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Compare word and flags
   task chk(input [46:0] seen, input [46:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED result op %h exp %h seen %h", op, exp, seen);
      end
   endtask
   // One instruction, answer read a cycle later
   task run(input [2:0] o, input [4:0] d, input [39:0] a, input m,
      input [46:0] e);
      @(negedge clk);
      P.regs[d] = a;
      {op, dst, src_data, overflow_mode_bit, op_valid} = {o, d, a, m, 1'b1};
      @(negedge clk);
      op_valid = 1'b0;
      chk({wr_data, carry_flag, overflow_flag, zero_flag, negative_flag,
         underflow_flag, latched_overflow_flag, latched_underflow_flag}, e);
   endtask
   // Reset, each rotate kind, both register classes, rounding
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      run(3'h1,5'h03,40'h80025cd4,1'b1,{40'h4b9a9,7'h40});
      run(3'h2,5'h03,40'h420,1'b0,{40'h841,7'h00});
      run(3'h3,5'h07,40'h421,1'b0,{40'h80000210,7'h48});
      run(3'h4,5'h04,40'h80000081,1'b1,{40'hc0000040,7'h48});
      run(3'h4,5'h14,40'h2,1'b0,{40'h80000001,7'h48});
      run(3'h1,5'h14,40'h80000000,1'b0,{40'h1,7'h48});
      run(3'h5,5'h02,40'h0733c16eef,1'b0,{40'h0733c16f00,7'h40});
      run(3'h5,5'h02,40'h8000000000,1'b0,{40'h8000000000,7'h44});
      run(3'h1,5'h00,40'h0500000000,1'b0,{40'h0500000000,7'h10});
      run(3'h5,5'h01,40'h7f7fffffc0,1'b1,{40'h7f7fffff00,7'h32});
      @(negedge clk);
      {op, op_valid} = {3'h6, 1'b1};
      @(negedge clk);
      op_valid = 1'b0;
      chk({46'h0, wr_en}, 47'h0);
      results;
   end
endmodule
